// [adc_conversion_control.sv]
// Control and status logic of the 10-bit converter
`timescale 1ns/10ps
module adc_conversion_control
  import adc_ctrl_pkg::*;
#(
  parameter int CONV_CYCLES = CONV_CYCLES_DEF
)(
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_b_in,
  // Register port
  input wire logic [ADDR_W-1:0] addr_in,
  input wire logic [DATA_W-1:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [DATA_W-1:0] rdata_out,
  // Hardware trigger pulse from the periodic counter
  input wire logic hw_trigger_in,
  // Analog front end
  input wire logic [RES_W-1:0] sample_in,
  output logic [CHAN_W-1:0] channel_out,
  output logic power_on_out,
  output logic isolate_out,
  // Interrupt
  output logic irq_out
);
  // Software visible control bits
  logic [CHAN_W-1:0] channel_select; // Channel code
  logic done_irq_enable; // Completion interrupt enable
  logic continuous_enable; // Continuous mode
  logic trigger_select; // 1 selects hardware trigger
  logic compare_enable; // Automatic compare on
  logic compare_greater_equal; // Compare direction
  logic [RES_W-1:0] compare_value; // Compare level
  // Status held by the block
  logic conv_done_flag; // Completion flag
  logic [RES_W-1:0] result; // Last stored result
  logic cont_run; // Back-to-back conversions armed
  logic [DATA_W-1:0] irq_status; // Sticky events
  logic [DATA_W-1:0] irq_mask; // Event gates
  logic [DATA_W-1:0] next_irq_status; // Status after this edge
  // Decoded accesses
  logic wr_cs1; // Write of first control register
  logic rd_resl; // Read of result low register
  logic sw_go; // Software start
  logic hw_go; // Hardware start
  logic cont_go; // Continuous restart
  logic cmp_hit; // Compare outcome of current result
  logic store_ok; // Completion that stores its result
  logic done_set; // Flag set this cycle

  conv_if cv();

  // Timing of one conversion
  conv_sequencer #(
    .CONV_CYCLES(CONV_CYCLES)
  ) u_seq (
    .sys_clk_in(sys_clk_in),
    .rst_b_in(rst_b_in),
    .sample_in(sample_in),
    .cv(cv)
  );

  conv_compare u_cmp (
    .result_in(cv.result),
    .value_in(compare_value),
    .greater_equal_in(compare_greater_equal),
    .hit_out(cmp_hit)
  );

  // Access decode
  always_comb begin
    wr_cs1 = wr_in && addr_in == OFS_CS1;
    rd_resl = rd_in && addr_in == OFS_RESL;
  end

  // Start sources; a write always has the last word
  always_comb begin
    sw_go = wr_cs1 && chan_on(wdata_in[CHAN_W-1:0])
      && !trigger_select;
    // trigger pulse is taken once per pulse
    hw_go = hw_trigger_in && trigger_select && !wr_cs1
      && chan_on(channel_select) && !cv.busy && !cont_run;
    cont_go = cv.done && cont_run && !wr_cs1;
    cv.start = sw_go || hw_go || cont_go;
    cv.abort = wr_cs1;
  end

  // Completion outcome
  always_comb begin
    store_ok = cv.done && (!compare_enable || cmp_hit);
    // compare on sets on hit only
    done_set = store_ok;
  end

  // First control register fields
  always_ff @(posedge sys_clk_in) begin
    if (!rst_b_in) begin
      channel_select <= CHAN_RST;
      done_irq_enable <= 1'b0;
      continuous_enable <= 1'b0;
    end else if (wr_cs1) begin
      channel_select <= wdata_in[CHAN_W-1:0];
      done_irq_enable <= wdata_in[CS1_IEN_BIT];
      continuous_enable <= wdata_in[CS1_CONT_BIT];
    end
  end

  // Second control register fields
  always_ff @(posedge sys_clk_in) begin
    if (!rst_b_in) begin
      trigger_select <= 1'b0;
      compare_enable <= 1'b0;
      compare_greater_equal <= 1'b0;
    end else if (wr_in && addr_in == OFS_CS2) begin
      // reserved low bits are not stored
      trigger_select <= wdata_in[CS2_TRIG_BIT];
      compare_enable <= wdata_in[CS2_CMPEN_BIT];
      compare_greater_equal <= wdata_in[CS2_GE_BIT];
    end
  end

  // Compare level, split over two registers
  always_ff @(posedge sys_clk_in) begin
    if (!rst_b_in) begin
      compare_value <= CMP_RST;
    end else if (wr_in && addr_in == OFS_CMPH) begin
      compare_value[9:8] <= wdata_in[1:0];
    end else if (wr_in && addr_in == OFS_CMPL) begin
      compare_value[7:0] <= wdata_in;
    end
  end

  // Continuous arming
  always_ff @(posedge sys_clk_in) begin
    if (!rst_b_in) begin
      cont_run <= 1'b0;
    end else if (wr_cs1) begin
      // all-ones stops continuous, no extra conversion
      cont_run <= sw_go && wdata_in[CS1_CONT_BIT];
    end else if (hw_go) begin
      cont_run <= continuous_enable;
    end
  end

  // Result store
  always_ff @(posedge sys_clk_in) begin
    if (!rst_b_in) begin
      result <= 10'h000;
    end else if (store_ok) begin
      result <= cv.result;
    end
  end

  // Completion flag: a set in the clearing cycle wins
  always_ff @(posedge sys_clk_in) begin
    if (!rst_b_in) begin
      conv_done_flag <= 1'b0;
    end else if (done_set) begin
      conv_done_flag <= 1'b1;
    end else if (wr_cs1 || rd_resl) begin
      // cleared by control write or low read
      conv_done_flag <= 1'b0;
    end
  end

  // Sticky events; write one to clear, set wins
  always_comb begin
    next_irq_status = irq_status;
    if (wr_in && addr_in == OFS_IRQ_STAT) begin
      next_irq_status = irq_status & ~wdata_in;
    end
    // only enabled completions raise an event
    if (done_set && done_irq_enable) begin
      next_irq_status[IRQ_DONE_BIT] = 1'b1;
    end
  end

  // Event register and mask
  always_ff @(posedge sys_clk_in) begin
    if (!rst_b_in) begin
      irq_status <= 8'h00;
      irq_mask <= MASK_RST;
    end else begin
      irq_status <= next_irq_status;
      if (wr_in && addr_in == OFS_IRQ_MASK) begin
        irq_mask <= wdata_in;
      end
    end
  end

  // Level interrupt from the gated status
  always_ff @(posedge sys_clk_in) begin
    if (!rst_b_in) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= |(next_irq_status & irq_mask);
    end
  end

  // Analog side controls
  always_ff @(posedge sys_clk_in) begin
    if (!rst_b_in) begin
      channel_out <= CHAN_RST;
      power_on_out <= 1'b0;
      isolate_out <= 1'b1;
    end else begin
      // code drives the input mux directly
      channel_out <= channel_select;
      // idle single mode falls to low power
      power_on_out <= cv.busy || cont_run;
      isolate_out <= !chan_on(channel_select);
    end
  end

  // Read data, one cycle after the strobe, zero otherwise
  always_ff @(posedge sys_clk_in) begin
    if (!rst_b_in) begin
      rdata_out <= 8'h00;
    end else if (rd_in) begin
      unique case (addr_in)
        OFS_CS1: begin
          rdata_out <= {conv_done_flag, done_irq_enable,
            continuous_enable, channel_select};
        end
        OFS_CS2: begin
          // active flag is the sequencer state
          rdata_out <= {cv.busy, trigger_select, compare_enable,
            compare_greater_equal, 4'h0};
        end
        OFS_RESH: begin
          rdata_out <= {6'h00, result[9:8]};
        end
        OFS_RESL: begin
          rdata_out <= result[7:0];
        end
        OFS_CMPH: begin
          rdata_out <= {6'h00, compare_value[9:8]};
        end
        OFS_CMPL: begin
          rdata_out <= compare_value[7:0];
        end
        OFS_IRQ_STAT: begin
          rdata_out <= irq_status;
        end
        OFS_IRQ_MASK: begin
          rdata_out <= irq_mask;
        end
      endcase
    end else begin
      rdata_out <= 8'h00;
    end
  end

  // Checks on the control behaviour
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!rst_b_in);

  sw_restart_a: assert property (
    wr_cs1 && chan_on(wdata_in[4:0]) && !trigger_select
      |=> cv.busy ##1 (cv.busy || $past(cv.abort)))
    else $error("control write did not restart");

  chan_off_a: assert property (
    wr_cs1 && !chan_on(wdata_in[4:0]) |=> !cv.busy && !cont_run)
    else $error("all-ones channel still converting");

  done_plain_a: assert property (
    cv.done && !compare_enable |=> conv_done_flag)
    else $error("done flag missed a completion");

  cmp_miss_a: assert property (
    cv.done && compare_enable && !cmp_hit && !wr_cs1 && !rd_resl
      |=> conv_done_flag == $past(conv_done_flag))
    else $error("flag moved on compare miss");

  flag_clear_a: assert property (
    (wr_cs1 || rd_resl) && !cv.done |=> !conv_done_flag)
    else $error("done flag not cleared");

  irq_gate_a: assert property (
    $rose(irq_status[IRQ_DONE_BIT]) |-> $past(done_irq_enable))
    else $error("event raised while disabled");

  // enabled completion reaches the pin on the next edge
  irq_pin_a: assert property (
    done_set && done_irq_enable && irq_mask[IRQ_DONE_BIT]
      |=> irq_out)
    else $error("interrupt output late");

  single_end_a: assert property (
    cv.done && !cont_run && !cv.start
      |=> !cv.busy ##1 (!cv.busy || $past(cv.start)))
    else $error("extra conversion in single mode");

  cont_next_a: assert property (
    cv.done && cont_run && !wr_cs1 |=> cv.busy)
    else $error("continuous run did not restart");

  low_power_a: assert property (
    cv.done && !cont_run && !cv.start |=> ##1 !power_on_out)
    else $error("power stayed on after single");

  abort_idle_a: assert property (
    cv.abort && !cv.start |=> !cv.busy)
    else $error("active flag kept after abort");

  hw_start_a: assert property (
    hw_go |=> cv.busy)
    else $error("hardware trigger ignored");

  res_store_a: assert property (
    store_ok |=> result == $past(cv.result))
    else $error("result not stored");

  // Main scenarios
  sw_single_c: cover property (sw_go ##[1:300] cv.done);
  hw_single_c: cover property (hw_go ##[1:300] cv.done);
  cont_two_c: cover property (cont_go ##[1:300] cont_go);
  cmp_miss_c: cover property (cv.done && compare_enable && !cmp_hit);
endmodule

// [adc_ctrl_pkg.sv]
// Shared constants for the converter control block
package adc_ctrl_pkg;
  // Data path widths
  localparam int DATA_W = 8;
  localparam int RES_W = 10;
  localparam int CHAN_W = 5;
  localparam int ADDR_W = 3;
  // Register offsets on the plain port
  localparam logic [2:0] OFS_CS1 = 3'h0;
  localparam logic [2:0] OFS_CS2 = 3'h1;
  localparam logic [2:0] OFS_RESH = 3'h2;
  localparam logic [2:0] OFS_RESL = 3'h3;
  localparam logic [2:0] OFS_CMPH = 3'h4;
  localparam logic [2:0] OFS_CMPL = 3'h5;
  localparam logic [2:0] OFS_IRQ_STAT = 3'h6;
  localparam logic [2:0] OFS_IRQ_MASK = 3'h7;
  // First control/status register fields
  localparam int CS1_DONE_BIT = 7;
  localparam int CS1_IEN_BIT = 6;
  localparam int CS1_CONT_BIT = 5;
  // Second control/status register fields
  localparam int CS2_ACT_BIT = 7;
  localparam int CS2_TRIG_BIT = 6;
  localparam int CS2_CMPEN_BIT = 5;
  localparam int CS2_GE_BIT = 4;
  // Interrupt status bit of the done event
  localparam int IRQ_DONE_BIT = 0;
  // Channel codes
  localparam logic [4:0] CHAN_RSVD = 5'h1c;
  localparam logic [4:0] CHAN_REFH = 5'h1d;
  localparam logic [4:0] CHAN_REFL = 5'h1e;
  localparam logic [4:0] CHAN_OFF = 5'h1f;
  // Reset values
  localparam logic [4:0] CHAN_RST = 5'h1f;
  localparam logic [9:0] CMP_RST = 10'h000;
  localparam logic [7:0] MASK_RST = 8'h00;
  // Default length of one conversion in clock cycles
  localparam int CONV_CYCLES_DEF = 16;
  // True when a channel code allows conversions and keeps the input connected
  function automatic logic chan_on(input logic [4:0] code);
    return code != CHAN_OFF;
  endfunction
endpackage

// [conv_if.sv]
// Handshake between control logic and conversion sequencer
`timescale 1ns/10ps
interface conv_if;
  logic start; // One-cycle start request
  logic abort; // One-cycle abort request
  logic busy; // Conversion in progress
  logic done; // One-cycle completion pulse
  logic [9:0] result; // Result, valid with done
  modport ctrl(output start, output abort, input busy, input done,
    input result);
  modport seq(input start, input abort, output busy, output done,
    output result);
endinterface

// [conv_compare.sv]
// Result against compare value, less-than or greater-equal
`timescale 1ns/10ps
module conv_compare
  import adc_ctrl_pkg::*;
(
  // Operands
  input wire logic [RES_W-1:0] result_in,
  input wire logic [RES_W-1:0] value_in,
  // Direction
  input wire logic greater_equal_in,
  // Outcome
  output logic hit_out
);
  // Pure comparison, no state
  always_comb begin
    if (greater_equal_in) begin
      hit_out = result_in >= value_in;
    end else begin
      hit_out = result_in < value_in;
    end
  end
endmodule

// [conv_sequencer.sv]
// Times one conversion and captures the analog result
`timescale 1ns/10ps
module conv_sequencer
  import adc_ctrl_pkg::*;
#(
  parameter int CONV_CYCLES = CONV_CYCLES_DEF
)(
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_b_in,
  // Analog front end code, sampled at the end
  input wire logic [RES_W-1:0] sample_in,
  // Control side
  conv_if.seq cv
);
  typedef enum logic {IDLE = 1'b0, CONVERT = 1'b1} seq_state_e;
  seq_state_e state; // Current phase
  logic [15:0] count; // Cycles left in conversion

  // Counter must hold the conversion length; refused at elaboration
  if (CONV_CYCLES < 1 || CONV_CYCLES > 65535) begin : g_len_check
    $error("CONV_CYCLES out of range");
  end

  // Phase, counter and result; abort wins over running
  always_ff @(posedge sys_clk_in) begin
    if (!rst_b_in) begin
      state <= IDLE;
      count <= 16'h0000;
      cv.done <= 1'b0;
      cv.result <= 10'h000;
    end else begin
      cv.done <= 1'b0;
      if (cv.start) begin
        // Restart, even over a running conversion
        state <= CONVERT;
        count <= 16'(CONV_CYCLES);
      end else if (cv.abort) begin
        state <= IDLE;
      end else begin
        unique case (state)
          IDLE: begin
            count <= 16'h0000;
          end
          CONVERT: begin
            if (count == 16'h0001) begin
              state <= IDLE;
              cv.done <= 1'b1;
              cv.result <= sample_in;
            end else begin
              count <= count - 16'h0001;
            end
          end
        endcase
      end
    end
  end

  assign cv.busy = state == CONVERT;
endmodule

// [analog_trigger_model.sv]
// Far side model: analog front end and periodic trigger counter
`timescale 1ns/10ps
module analog_trigger_model
  import adc_ctrl_pkg::*;
#(
  parameter int PERIOD = 20
)(
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_b_in,
  // Bench controls
  input wire logic count_en_in,
  input wire logic [RES_W-1:0] level_in,
  // Converter side
  input wire logic [CHAN_W-1:0] channel_in,
  input wire logic power_on_in,
  output logic [RES_W-1:0] sample_out,
  output logic hw_trigger_out
);
  int count; // Periodic counter
  logic [RES_W-1:0] junk; // Pattern for an unpowered input

  always_ff @(posedge sys_clk_in) begin
    if (!rst_b_in || !count_en_in) begin
      count <= 0;
      hw_trigger_out <= 1'b0;
    end else begin
      hw_trigger_out <= (count == PERIOD - 1);
      count <= (count == PERIOD - 1) ? 0 : count + 1;
    end
  end

  // Toggles every cycle so a stale sample never looks valid
  always_ff @(posedge sys_clk_in) begin
    if (!rst_b_in) begin
      junk <= 10'h155;
    end else begin
      junk <= ~junk;
    end
  end

  // When powered, references give full and zero scale, other codes the bench level; unpowered gives junk
  always_comb begin
    if (!power_on_in) begin
      sample_out = junk;
    end else if (channel_in == CHAN_REFH) begin
      sample_out = 10'h3ff;
    end else if (channel_in == CHAN_REFL) begin
      sample_out = 10'h000;
    end else begin
      sample_out = level_in;
    end
  end
endmodule

// [test_adc_conversion_control.sv]
// Self-checking bench of the converter control block
`timescale 1ns/10ps
module test_adc_conversion_control import adc_ctrl_pkg::*;;
  localparam int CONV = 4; // Short conversions keep the run brief
  localparam int SETTLE = CONV + 4; // Write to done flag, with margin
  typedef struct {string name; logic [7:0] exp;} note_s;
  logic sys_clk, rst_b, wr, rd, hw_trig, power_on, isolate, irq;
  logic count_en, rd_seen;
  logic [2:0] addr;
  logic [7:0] wdata, rdata;
  logic [9:0] level, sample, last, v;
  logic [4:0] channel;
  logic ge, hit;
  note_s notes[$]; // Expected read data, oldest first
  note_s nt;
  int err_count, compares, seed;
  logic [4:0] codes [6] = '{5'h00, 5'h0b, 5'h1b, CHAN_RSVD, CHAN_REFH,
    CHAN_REFL};

  adc_conversion_control #(.CONV_CYCLES(CONV)) u_adc_conversion_control (
    .sys_clk_in(sys_clk), .rst_b_in(rst_b), .addr_in(addr),
    .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata),
    .hw_trigger_in(hw_trig), .sample_in(sample), .channel_out(channel),
    .power_on_out(power_on), .isolate_out(isolate), .irq_out(irq));

  analog_trigger_model #(.PERIOD(20)) u_analog_trigger_model (
    .sys_clk_in(sys_clk), .rst_b_in(rst_b), .count_en_in(count_en),
    .level_in(level), .channel_in(channel), .power_on_in(power_on),
    .sample_out(sample), .hw_trigger_out(hw_trig));

  task automatic check(input string name, input logic [7:0] seen,
    input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic summarize();
    if (err_count == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // One-cycle write; the strobe drops on the next edge
  task automatic reg_wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge sys_clk);
    wr <= 1'b0;
  endtask

  // One-cycle read; the monitor compares the data a cycle later
  task automatic reg_rd(input logic [2:0] a, input logic [7:0] e,
    input string nm);
    @(posedge sys_clk);
    addr <= a;
    rd <= 1'b1;
    notes.push_back('{nm, e});
    @(posedge sys_clk);
    rd <= 1'b0;
  endtask

  task automatic idle(input int k);
    repeat (k) @(posedge sys_clk);
  endtask

  // Let the counter run until one trigger pulse has gone out
  task automatic one_pulse();
    int k;
    k = 0;
    count_en <= 1'b1;
    while (hw_trig !== 1'b1 && k < 200) begin
      @(posedge sys_clk);
      k++;
    end
    // A missing pulse counts as a mismatch
    if (k >= 200) begin
      err_count++;
    end
    count_en <= 1'b0;
  endtask

  // Single software conversion on one channel code
  task automatic single(input logic [4:0] c);
    logic [9:0] r;
    logic [9:0] e;
    r = 10'($random(seed));
    level <= r;
    e = (c == CHAN_REFH) ? 10'h3ff : (c == CHAN_REFL) ? 10'h000 : r;
    reg_wr(OFS_CS1, {3'h0, c});
    idle(2);
    check("channel", {3'h0, channel}, {3'h0, c});
    check("isolate", {7'h0, isolate}, 8'h00);
    reg_rd(OFS_CS2, 8'h80, "active");
    idle(SETTLE);
    check("power", {7'h0, power_on}, 8'h00);
    reg_rd(OFS_CS1, {3'h4, c}, "done set");
    reg_rd(OFS_CS2, 8'h00, "active clear");
    reg_rd(OFS_RESH, {6'h0, e[9:8]}, "result high");
    reg_rd(OFS_RESL, e[7:0], "result low");
    reg_rd(OFS_CS1, {3'h0, c}, "done clear");
  endtask

  // Read data stand one cycle after the strobe
  always @(posedge sys_clk) begin
    if (rd_seen) begin
      nt = notes.pop_front();
      check(nt.name, rdata, nt.exp);
    end
    rd_seen <= rd;
  end

  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  // Watchdog: a hang counts as a mismatch
  initial begin
    repeat (20000) @(posedge sys_clk);
    err_count++;
    summarize();
  end

  initial begin
    rst_b = 1'b0;
    addr = 3'h0;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
    count_en = 1'b0;
    level = 10'h000;
    seed = 30;
    err_count = 0;
    compares = 0;
    repeat (12) @(posedge sys_clk);
    rst_b <= 1'b1;
    // Reset state
    check("reset isolate", {7'h0, isolate}, 8'h01);
    reg_rd(OFS_CS1, {3'h0, CHAN_RST}, "cs1 reset");
    reg_rd(OFS_CS2, 8'h00, "cs2 reset");
    reg_rd(OFS_IRQ_MASK, MASK_RST, "mask reset");
    // Every kind of channel code but the off code
    foreach (codes[i]) begin
      single(codes[i]);
    end
    // Interrupt raised, cleared, then withheld without enable
    reg_wr(OFS_IRQ_MASK, 8'h01);
    reg_wr(OFS_CS1, 8'h42);
    idle(SETTLE);
    check("irq on", {7'h0, irq}, 8'h01);
    reg_rd(OFS_IRQ_STAT, 8'h01, "irq status");
    reg_wr(OFS_IRQ_STAT, 8'h01);
    idle(2);
    check("irq cleared", {7'h0, irq}, 8'h00);
    reg_wr(OFS_CS1, 8'h02);
    idle(SETTLE);
    check("irq off", {7'h0, irq}, 8'h00);
    reg_rd(OFS_CS1, 8'h82, "done no irq");
    reg_rd(OFS_IRQ_STAT, 8'h00, "no event");
    // Abort with restart, then abort with channel off
    reg_wr(OFS_CS1, 8'h03);
    level <= 10'h2a5;
    reg_wr(OFS_CS1, 8'h05);
    idle(SETTLE);
    reg_rd(OFS_CS1, 8'h85, "restart done");
    reg_rd(OFS_RESL, 8'ha5, "restart result");
    reg_wr(OFS_CS1, 8'h03);
    reg_wr(OFS_CS1, 8'h1f);
    idle(SETTLE);
    reg_rd(OFS_CS1, 8'h1f, "aborted");
    reg_rd(OFS_CS2, 8'h00, "abort inactive");
    check("off isolate", {7'h0, isolate}, 8'h01);
    // Continuous conversions, stopped by channel off
    v = 10'($random(seed));
    level <= v;
    reg_wr(OFS_CS1, 8'h26);
    idle(3 * (CONV + 1) + 4);
    check("cont power", {7'h0, power_on}, 8'h01);
    reg_rd(OFS_CS1, 8'ha6, "cont done");
    reg_rd(OFS_RESL, v[7:0], "cont result");
    // Spacing keeps the stop write off a completion edge
    idle(CONV + 5);
    reg_rd(OFS_CS1, 8'ha6, "cont again");
    reg_wr(OFS_CS1, 8'h1f);
    idle(SETTLE);
    reg_rd(OFS_CS1, 8'h1f, "cont stopped");
    check("stop power", {7'h0, power_on}, 8'h00);
    // Compare both ways, hit and miss
    reg_wr(OFS_CMPH, 8'h02);
    reg_wr(OFS_CMPL, 8'h00);
    reg_rd(OFS_CMPH, 8'h02, "compare value high");
    reg_rd(OFS_CMPL, 8'h00, "compare value low");
    last = 10'h000;
    for (int i = 0; i < 4; i++) begin
      ge = i[1];
      v = (i == 1 || i == 2) ? 10'h200 : 10'h1ff;
      hit = ge ? (v >= 10'h200) : (v < 10'h200);
      level <= v;
      reg_wr(OFS_CS2, {3'h1, ge, 4'h0});
      reg_wr(OFS_CS1, 8'h07);
      idle(SETTLE);
      if (hit) begin
        last = v;
      end
      reg_rd(OFS_CS1, {hit, 7'h07}, "compare flag");
      reg_rd(OFS_RESL, last[7:0], "compare low");
      reg_rd(OFS_RESH, {6'h0, last[9:8]}, "compare high");
    end
    // Hardware trigger: a write alone starts nothing
    reg_wr(OFS_CS2, 8'h40);
    reg_wr(OFS_CS1, 8'h04);
    idle(SETTLE);
    reg_rd(OFS_CS1, 8'h04, "no sw start");
    one_pulse();
    idle(SETTLE);
    reg_rd(OFS_CS1, 8'h84, "hw done");
    reg_rd(OFS_RESL, 8'hff, "hw result");
    idle(SETTLE);
    reg_rd(OFS_CS1, 8'h04, "one per pulse");
    // Hardware trigger with continuous mode: one pulse, endless run
    reg_wr(OFS_CS1, 8'h24);
    one_pulse();
    idle(3 * (CONV + 1) + 4);
    check("hw cont power", {7'h0, power_on}, 8'h01);
    reg_rd(OFS_CS1, 8'ha4, "hw cont done");
    reg_wr(OFS_CS1, 8'h1f);
    idle(SETTLE);
    check("hw cont stop", {7'h0, power_on}, 8'h00);
    reg_rd(OFS_CS2, 8'h40, "hw cont inactive");
    reg_wr(OFS_CS2, 8'h00);
    idle(4);
    summarize();
  end
endmodule
